// ==== include/twaux_pkg.sv ====
package twaux_pkg;
   localparam int NUM_CHAN = 4;
   localparam int FRAME_BITS = 11;
   localparam int PARITY_EDGE = 10;
   localparam int TMR_W = 22;

   // Timing, in the unit printed, and derived cycle counts
   localparam int CLK_PERIOD_NS = 10;
   localparam int BIT_TIMEOUT_US = 300;
   localparam int BIT_TIMEOUT_CYC = BIT_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
   localparam int FRAME_TIMEOUT_US = 2000;
   localparam int FRAME_TIMEOUT_CYC =
      FRAME_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
   localparam int ACK_TIMEOUT_US = 25000;
   localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
   localparam int HOLD_US = 300;
   localparam int HOLD_CYC =
      (HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TX_SETUP_NS = 80;
   localparam int TX_SETUP_CYC = (TX_SETUP_NS / CLK_PERIOD_NS < 1) ? 1 :
      TX_SETUP_NS / CLK_PERIOD_NS;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_CHAN_BASE = 16'h7F41;
   localparam logic [15:0] IDX_CHAN_LAST = 16'h7F4F;
   localparam logic [15:0] IDX_CONFIG = 16'h7FF4;
   localparam logic [1:0] REG_DATA = 2'h0;
   localparam logic [1:0] REG_CTRL = 2'h1;
   localparam logic [1:0] REG_STATUS = 2'h2;
   localparam int CFG_SEL_BIT = 4;

   localparam logic [7:0] CFG_RESET = 8'h10;
   localparam logic [7:0] CTRL_RESET = 8'h40;
   localparam logic [7:0] RX_RESET = 8'hFF;

   typedef struct packed {
      logic wr_clk;
      logic wr_data;
      logic stop;
      logic spare;
      logic [1:0] parity;
      logic auto_en;
      logic tr_sel;
   } twaux_ctrl_t;

   typedef struct packed {
      logic zero;
      logic par_err;
      logic dat_in;
      logic clk_in;
      logic tx_to;
      logic tx_idle;
      logic rx_to;
      logic rx_rdy;
   } twaux_stat_t;

   typedef enum logic [3:0] {
      ST_OFF, ST_RX_WAIT, ST_RX, ST_RX_FULL, ST_TX_WAIT,
      ST_TX_START, ST_TX_ACK, ST_TX, ST_HOLD
   } twaux_state_t;
endpackage

// ==== logic/twaux_sync.sv ====
`timescale 1ns/1ps
module twaux_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Asynchronous levels in, filtered levels out
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_level
);
   logic [W-1:0] ff1_q;
   logic [W-1:0] ff2_q;
   logic [W-1:0] ff3_q;
   wire [W-1:0] agree = ~(ff2_q ^ ff3_q);

   // Idle lines are pulled up, so everything resets high
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ff1_q <= '1;
         ff2_q <= '1;
         ff3_q <= '1;
         o_level <= '1;
      end
      else
      begin
         ff1_q <= i_async;
         ff2_q <= ff1_q;
         ff3_q <= ff2_q;
         o_level <= (agree & ff3_q) | (~agree & o_level);
      end
   end
endmodule

// ==== logic/twaux_top.sv ====
`timescale 1ns/1ps
module twaux_top
   import twaux_pkg::*;
#(
   parameter int BIT_TIMEOUT_CYCLES = twaux_pkg::BIT_TIMEOUT_CYC,
   parameter int FRAME_TIMEOUT_CYCLES = twaux_pkg::FRAME_TIMEOUT_CYC,
   parameter int ACK_TIMEOUT_CYCLES = twaux_pkg::ACK_TIMEOUT_CYC,
   parameter int HOLD_CYCLES = twaux_pkg::HOLD_CYC
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Link lines, index 0 to 3 is channel a to d
   input wire logic [twaux_pkg::NUM_CHAN-1:0] i_clock_line_in,
   output logic [twaux_pkg::NUM_CHAN-1:0] o_clock_line_out,
   output logic [twaux_pkg::NUM_CHAN-1:0] o_clock_line_oe,
   input wire logic [twaux_pkg::NUM_CHAN-1:0] i_data_line_in,
   output logic [twaux_pkg::NUM_CHAN-1:0] o_data_line_out,
   output logic [twaux_pkg::NUM_CHAN-1:0] o_data_line_oe,
   // Per-channel event pulse
   output logic [twaux_pkg::NUM_CHAN-1:0] o_event
);
   import twaux_pkg::*;

   localparam logic [TMR_W-1:0] BIT_LIM = TMR_W'(BIT_TIMEOUT_CYCLES);
   localparam logic [TMR_W-1:0] FRM_LIM = TMR_W'(FRAME_TIMEOUT_CYCLES);
   localparam logic [TMR_W-1:0] ACK_LIM = TMR_W'(ACK_TIMEOUT_CYCLES);
   localparam logic [TMR_W-1:0] HOLD_LAST = TMR_W'(HOLD_CYCLES - 1);
   localparam logic [TMR_W-1:0] SETUP_LAST = TMR_W'(TX_SETUP_CYC - 1);
   localparam logic [3:0] EDGE_PAR = 4'(PARITY_EDGE);
   localparam logic [3:0] EDGE_LAST = 4'(FRAME_BITS);

   logic rst1_q;
   logic rst_n;

   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rst1_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst1_q <= 1'b1;
         rst_n <= rst1_q;
      end
   end

   // Line inputs: clocks in the low half, data in the high half
   logic [2*NUM_CHAN-1:0] line_lv;

   twaux_sync #(.W(2 * NUM_CHAN)) u_sync (
      .i_clock(i_clock),
      .i_rst_n(rst_n),
      .i_async({i_data_line_in, i_clock_line_in}),
      .o_level(line_lv)
   );

   // APB decode
   logic [7:0] cfg_q;
   logic pready_q;
   logic [7:0] chan_rd [NUM_CHAN];
   wire [15:0] idx = i_paddr[17:2];
   wire [15:0] off = idx - IDX_CHAN_BASE;
   wire addr_ok = (i_paddr[31:18] == 14'h0000) && (i_paddr[1:0] == 2'h0);
   wire hit_cfg = addr_ok && (idx == IDX_CONFIG);
   wire hit_chan = addr_ok && (idx >= IDX_CHAN_BASE) &&
      (idx <= IDX_CHAN_LAST) && (off[1:0] != 2'h3);
   wire cfg_sel = cfg_q[CFG_SEL_BIT];
   wire chan_live = hit_chan && cfg_sel;
   wire [1:0] sel_ch = off[3:2];
   wire [1:0] sel_reg = off[1:0];
   wire setup = i_psel && !i_penable;
   wire access = i_psel && i_penable && pready_q;
   wire wr_acc = access && i_pwrite;
   // Read side effects act at the setup edge, where the data is captured
   wire rd_setup = setup && !i_pwrite && chan_live;
   wire [7:0] rd_mux = hit_cfg ? cfg_q :
      (chan_live ? chan_rd[sel_ch] : 8'h00);

   // Zero wait states: pready is high in every access phase
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_q <= 1'b0;
         o_pready <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
         cfg_q <= CFG_RESET;
      end
      else
      begin
         pready_q <= setup;
         o_pready <= setup;
         // Error stands only in the access cycle, like pready
         o_pslverr <= setup && !(hit_cfg || hit_chan);
         if (setup)
            o_prdata <= {24'h00_0000, rd_mux};
         if (wr_acc && hit_cfg)
            cfg_q <= i_pwdata[7:0];
      end
   end

   for (genvar c = 0; c < NUM_CHAN; c++)
   begin : g_chan
      twaux_state_t st_q, st_d;
      twaux_ctrl_t ctrl_q, ctrl_d;
      twaux_stat_t stat;
      logic [7:0] rx_q, rx_d;
      logic [10:0] sh_q, sh_d;
      logic [3:0] edge_q, edge_d;
      logic [TMR_W-1:0] bit_tmr_q, bit_tmr_d, frm_tmr_q, frm_tmr_d;
      logic rx_rdy_q, rx_rdy_d, rx_to_q, rx_to_d, tx_to_q, tx_to_d;
      logic tx_idle_q, tx_idle_d, par_err_q, par_err_d;
      logic tx_pend_q, tx_pend_d, clk_prev_q, evt_d;
      logic clk_oe_d, dat_oe_d;

      wire clk_lv = line_lv[c];
      wire dat_lv = line_lv[NUM_CHAN + c];
      wire fall = clk_prev_q && !clk_lv;
      wire me = (sel_ch == 2'(c));
      wire wr_data = wr_acc && chan_live && me && (sel_reg == REG_DATA);
      wire wr_ctrl = wr_acc && chan_live && me && (sel_reg == REG_CTRL);
      wire rd_data = rd_setup && me && (sel_reg == REG_DATA);
      wire rd_stat = rd_setup && me && (sel_reg == REG_STATUS);
      wire bit_late = bit_tmr_q >= BIT_LIM;
      wire frm_late = frm_tmr_q >= FRM_LIM;
      wire accept = wr_data && ctrl_q.auto_en && ctrl_q.tr_sel &&
         tx_idle_q && !rx_rdy_q && (st_q != ST_RX);

      assign stat = '{zero: 1'b0, par_err: par_err_q, dat_in: dat_lv,
         clk_in: clk_lv, tx_to: tx_to_q, tx_idle: tx_idle_q,
         rx_to: rx_to_q, rx_rdy: rx_rdy_q};
      assign chan_rd[c] = (sel_reg == REG_DATA) ? rx_q :
         ((sel_reg == REG_CTRL) ? ctrl_q :
         ((sel_reg == REG_STATUS) ? stat : 8'h00));

      always_comb
      begin
         st_d = st_q;
         ctrl_d = ctrl_q;
         rx_d = rx_q;
         sh_d = sh_q;
         edge_d = edge_q;
         bit_tmr_d = bit_tmr_q + TMR_W'(1);
         frm_tmr_d = frm_tmr_q + TMR_W'(1);
         rx_rdy_d = rx_rdy_q;
         rx_to_d = rx_to_q;
         tx_to_d = tx_to_q;
         tx_idle_d = tx_idle_q;
         par_err_d = par_err_q;
         tx_pend_d = tx_pend_q;
         evt_d = 1'b0;
         if (wr_ctrl)
            ctrl_d = i_pwdata[7:0];
         if (rd_data)
         begin
            rx_rdy_d = 1'b0;
            rx_d = RX_RESET;
         end
         if (rd_stat)
         begin
            rx_to_d = 1'b0;
            tx_to_d = 1'b0;
            par_err_d = 1'b0;
         end
         case (st_q)
            ST_OFF:
            begin
               if (!tx_pend_q)
                  tx_idle_d = 1'b1;
               st_d = ctrl_q.tr_sel ? ST_TX_WAIT : ST_RX_WAIT;
            end
            ST_RX_WAIT:
            begin
               if (ctrl_q.tr_sel)
                  st_d = ST_TX_WAIT;
               else if (rx_rdy_q)
                  st_d = ST_RX_FULL;
               else if (fall && !dat_lv)
               begin
                  st_d = ST_RX;
                  edge_d = 4'd1;
                  bit_tmr_d = '0;
                  frm_tmr_d = '0;
               end
            end
            ST_RX:
            begin
               if (ctrl_q.tr_sel && edge_q < EDGE_PAR)
                  st_d = ST_TX_WAIT;
               else if (fall)
               begin
                  edge_d = edge_q + 4'd1;
                  bit_tmr_d = '0;
                  if (edge_q < EDGE_PAR - 4'd1)
                     sh_d[7:0] = {dat_lv, sh_q[7:1]};
                  else if (edge_q == EDGE_PAR - 4'd1)
                     sh_d[8] = dat_lv;
                  else if (dat_lv && (^sh_q[8:0]))
                  begin
                     rx_d = sh_q[7:0];
                     rx_rdy_d = 1'b1;
                     evt_d = 1'b1;
                     st_d = ST_RX_FULL;
                  end
                  else
                  begin
                     par_err_d = 1'b1;
                     st_d = ST_RX_WAIT;
                  end
               end
               else if (bit_late || frm_late)
               begin
                  rx_to_d = 1'b1;
                  rx_d = RX_RESET;
                  evt_d = 1'b1;
                  bit_tmr_d = '0;
                  st_d = ST_HOLD;
               end
            end
            ST_RX_FULL:
            begin
               if (!rx_rdy_q)
                  st_d = ctrl_q.tr_sel ? ST_TX_WAIT : ST_RX_WAIT;
            end
            ST_TX_WAIT:
            begin
               if (!ctrl_q.tr_sel)
                  st_d = ST_RX_WAIT;
               else if (tx_pend_q && !rx_rdy_q)
               begin
                  st_d = ST_TX_START;
                  tx_pend_d = 1'b0;
                  bit_tmr_d = '0;
               end
            end
            ST_TX_START:
            begin
               if (bit_tmr_q >= SETUP_LAST)
               begin
                  st_d = ST_TX_ACK;
                  frm_tmr_d = '0;
               end
            end
            ST_TX_ACK, ST_TX:
            begin
               if (fall)
               begin
                  st_d = ST_TX;
                  bit_tmr_d = '0;
                  sh_d = {1'b1, sh_q[10:1]};
                  if (st_q == ST_TX_ACK)
                  begin
                     edge_d = 4'd1;
                     frm_tmr_d = '0;
                  end
                  else
                     edge_d = edge_q + 4'd1;
                  if (st_q == ST_TX && edge_q == EDGE_LAST - 4'd1)
                  begin
                     ctrl_d.tr_sel = 1'b0;
                     tx_idle_d = 1'b1;
                     evt_d = 1'b1;
                     st_d = ST_RX_WAIT;
                  end
               end
               else if ((st_q == ST_TX_ACK && frm_tmr_q >= ACK_LIM) ||
                        (st_q == ST_TX && (bit_late || frm_late)))
               begin
                  tx_to_d = 1'b1;
                  ctrl_d.tr_sel = 1'b0;
                  tx_idle_d = 1'b1;
                  rx_d = RX_RESET;
                  sh_d = '1;
                  evt_d = 1'b1;
                  bit_tmr_d = '0;
                  st_d = ST_HOLD;
               end
            end
            ST_HOLD:
            begin
               if (bit_tmr_q >= HOLD_LAST)
                  st_d = ctrl_d.tr_sel ? ST_TX_WAIT : ST_RX_WAIT;
            end
            default:
               st_d = ST_OFF;
         endcase
         if (accept)
         begin
            tx_pend_d = 1'b1;
            tx_idle_d = 1'b0;
            sh_d = {1'b1, ~^i_pwdata[7:0], i_pwdata[7:0], 1'b0};
         end
         if (!cfg_sel || !ctrl_q.auto_en)
            st_d = ST_OFF;
      end

      // Line drive follows the next state so the pins move with it
      always_comb
      begin
         clk_oe_d = 1'b0;
         dat_oe_d = 1'b0;
         case (st_d)
            ST_OFF:
            begin
               clk_oe_d = cfg_sel && !ctrl_d.wr_clk;
               dat_oe_d = cfg_sel && !ctrl_d.wr_data;
            end
            ST_RX_FULL, ST_TX_WAIT, ST_HOLD:
               clk_oe_d = 1'b1;
            ST_TX_START:
            begin
               clk_oe_d = 1'b1;
               dat_oe_d = !sh_d[0];
            end
            ST_TX_ACK, ST_TX:
               dat_oe_d = !sh_d[0];
            default:
               clk_oe_d = 1'b0;
         endcase
      end

      always_ff @(posedge i_clock or negedge rst_n)
      begin
         if (!rst_n)
         begin
            st_q <= ST_OFF;
            ctrl_q <= CTRL_RESET;
            rx_q <= RX_RESET;
            sh_q <= '1;
            edge_q <= 4'h0;
            bit_tmr_q <= '0;
            frm_tmr_q <= '0;
            {rx_rdy_q, rx_to_q, tx_to_q, par_err_q, tx_pend_q} <= 5'h00;
            tx_idle_q <= 1'b1;
            clk_prev_q <= 1'b1;
            o_event[c] <= 1'b0;
            o_clock_line_oe[c] <= 1'b1;
            o_data_line_oe[c] <= 1'b0;
            o_clock_line_out[c] <= 1'b0;
            o_data_line_out[c] <= 1'b0;
         end
         else
         begin
            st_q <= st_d;
            ctrl_q <= ctrl_d;
            rx_q <= rx_d;
            sh_q <= sh_d;
            edge_q <= edge_d;
            bit_tmr_q <= bit_tmr_d;
            frm_tmr_q <= frm_tmr_d;
            {rx_rdy_q, rx_to_q, tx_to_q, par_err_q, tx_pend_q} <=
               {rx_rdy_d, rx_to_d, tx_to_d, par_err_d, tx_pend_d};
            tx_idle_q <= tx_idle_d;
            clk_prev_q <= clk_lv;
            o_event[c] <= evt_d;
            o_clock_line_oe[c] <= clk_oe_d;
            o_data_line_oe[c] <= dat_oe_d;
            o_clock_line_out[c] <= 1'b0;
            o_data_line_out[c] <= 1'b0;
         end
      end
   end
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import twaux_pkg::*;
   localparam logic [31:0] A_DAT = {14'h0000, IDX_CHAN_BASE, 2'b00};
   localparam logic [31:0] A_CTL = A_DAT + 32'h0000_0004;
   localparam logic [31:0] A_STS = A_DAT + 32'h0000_0008;
   localparam logic [31:0] A_CFG = {14'h0000, IDX_CONFIG, 2'b00};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [31:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic [3:0] cl_oe, cl_out, dl_oe, dl_out, ev;
   wire [3:0] cl_in;
   wire [3:0] dl_in;
   logic [9:0] fr;
   int num_errors = 0;
   int cmp_count = 0;
   always #5 clk = ~clk;
   // Unused channels see only their own drive against the pull-ups
   assign cl_in[3:1] = ~cl_oe[3:1];
   assign dl_in[3:1] = ~dl_oe[3:1];
   twaux_top #(.BIT_TIMEOUT_CYCLES(300), .FRAME_TIMEOUT_CYCLES(2000),
      .ACK_TIMEOUT_CYCLES(5000), .HOLD_CYCLES(300)) u_twaux_top (
      .i_clock(clk), .i_resetn(rst_n), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_clock_line_in(cl_in), .o_clock_line_out(cl_out),
      .o_clock_line_oe(cl_oe), .i_data_line_in(dl_in),
      .o_data_line_out(dl_out), .o_data_line_oe(dl_oe), .o_event(ev));
   twaux_periph u_twaux_periph (.i_dev_clk_oe(cl_oe[0]),
      .i_dev_dat_oe(dl_oe[0]), .o_clk_line(cl_in[0]),
      .o_dat_line(dl_in[0]));
   task automatic cmp(input string nm, input logic [31:0] exp, got);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // Answer is taken at the rising edge that ends the access phase
      do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
      cmp("pready", 1'b1, pready);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [31:0] a, exp);
      apb(1'b0, a, '0);
      cmp(nm, exp, rd);
   endtask
   task automatic wev(input int lim);
      int n;
      n = 0;
      do @(negedge clk); while (ev[0] !== 1'b1 && ++n < lim);
      cmp("event", 1'b1, ev[0]);
   endtask
   task automatic end_sim;
      if (num_errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      #500000;
      num_errors++;
      end_sim;
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(negedge clk);
      cmp("clk_oe", 4'hF, cl_oe);
      cmp("line_out", 8'h00, {cl_out, dl_out});
      rchk("config", A_CFG, 32'h0000_0010);
      rchk("ctrl", A_CTL, 32'h0000_0040);
      rchk("status", A_STS, 32'h0000_0024);
      apb(1'b0, 32'h0000_0100, '0);
      cmp("slverr", 1'b1, err);
      apb(1'b1, A_CTL, 32'h0000_0080);
      repeat (8) @(negedge clk);
      cmp("bitbang", 2'b10, {dl_oe[0], cl_oe[0]});
      rchk("bb_status", A_STS, 32'h0000_0014);
      apb(1'b1, A_CTL, 32'h0000_0040);
      repeat (8) @(negedge clk);
      cmp("busy", 2'b01, {dl_oe[0], cl_oe[0]});
      apb(1'b1, A_CFG, '0);
      repeat (8) @(negedge clk);
      cmp("desel", 1'b0, cl_oe[0]);
      rchk("desel_ctrl", A_CTL, '0);
      apb(1'b1, A_CFG, 32'h0000_0010);
      apb(1'b1, A_CTL, 32'h0000_0002);
      fork
         u_twaux_periph.send(8'hA5, 1'b0, 11, 80);
         wev(400);
      join
      repeat (8) @(negedge clk);
      cmp("rx_hold", 1'b1, cl_oe[0]);
      rchk("rx_status", A_STS, 32'h0000_0025);
      rchk("rx_byte", A_DAT, 32'h0000_00A5);
      repeat (8) @(negedge clk);
      cmp("rx_free", 1'b0, cl_oe[0]);
      rchk("rx_reload", A_DAT, 32'h0000_00FF);
      u_twaux_periph.send(8'h5A, 1'b1, 11, 80);
      repeat (8) @(negedge clk);
      rchk("par_status", A_STS, 32'h0000_0074);
      // A sender that stalls mid-frame trips the per-bit limit
      u_twaux_periph.send(8'h33, 1'b0, 4, 80);
      wev(400);
      repeat (8) @(negedge clk);
      rchk("bit_to", A_STS, 32'h0000_0026);
      rchk("to_reload", A_DAT, 32'h0000_00FF);
      repeat (240) @(negedge clk);
      cmp("hold_on", 1'b1, cl_oe[0]);
      repeat (70) @(negedge clk);
      cmp("hold_off", 1'b0, cl_oe[0]);
      // Slow but legal bits still overrun the whole-frame limit
      fork
         u_twaux_periph.send(8'h11, 1'b0, 10, 1200);
         wev(2500);
      join
      rchk("frame_to", A_STS, 32'h0000_0036);
      // Switching to transmit before parity drops the byte
      fork
         u_twaux_periph.send(8'h99, 1'b0, 11, 800);
         begin
            repeat (300) @(negedge clk);
            apb(1'b1, A_CTL, 32'h0000_0003);
         end
      join
      rchk("abort", A_STS, 32'h0000_0024);
      cmp("tx_ready", 2'b01, {dl_oe[0], cl_oe[0]});
      fork
         u_twaux_periph.recv(fr);
         begin
            apb(1'b1, A_DAT, 32'h0000_003C);
            wev(400);
         end
      join
      cmp("tx_frame", {1'b1, ~^8'h3C, 8'h3C}, fr);
      rchk("tx_done", A_CTL, 32'h0000_0002);
      apb(1'b1, A_DAT, 32'h0000_0077);
      repeat (20) @(negedge clk);
      cmp("tx_refused", 1'b0, dl_oe[0]);
      rchk("refused_sts", A_STS, 32'h0000_0034);
      apb(1'b1, A_CTL, 32'h0000_0003);
      apb(1'b1, A_DAT, 32'h0000_0055);
      wev(6000);
      rchk("ack_to", A_CTL, 32'h0000_0002);
      rchk("ack_sts", A_STS, 32'h0000_002C);
      end_sim;
   end
endmodule
bind twaux_top twaux_chk u_twaux_chk (.i_clock, .i_resetn, .i_psel,
   .i_penable, .o_prdata, .o_pready, .o_pslverr, .i_clock_line_in,
   .o_clock_line_out, .o_clock_line_oe, .o_data_line_out,
   .o_data_line_oe, .o_event);

// ==== sim/twaux_chk_sva.sv ====
`timescale 1ns/1ps
module twaux_chk
   import twaux_pkg::*;
(
   // Clock, reset and bus
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // Link lines and events
   input wire logic [twaux_pkg::NUM_CHAN-1:0] i_clock_line_in,
   input wire logic [twaux_pkg::NUM_CHAN-1:0] o_clock_line_out,
   input wire logic [twaux_pkg::NUM_CHAN-1:0] o_clock_line_oe,
   input wire logic [twaux_pkg::NUM_CHAN-1:0] o_data_line_out,
   input wire logic [twaux_pkg::NUM_CHAN-1:0] o_data_line_oe,
   input wire logic [twaux_pkg::NUM_CHAN-1:0] o_event
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);
   // No earlier sample exists at the first edge, so that edge is skipped
   logic seen_q = 1'b0;
   always @(posedge i_clock)
      seen_q <= 1'b1;
   sequence s_tx_start;
      $rose(o_data_line_oe[0]) && o_clock_line_oe[0];
   endsequence
   sequence s_clock_freed;
      o_clock_line_oe[0] [*7] ##[1:3] !o_clock_line_oe[0];
   endsequence
   chk_pready_follows: assert property (
      i_psel && !i_penable |=> o_pready)
      else $error("pready missing after setup");
   chk_pready_single: assert property (o_pready |=> !o_pready)
      else $error("pready longer than one cycle");
   chk_err_gated: assert property (o_pslverr |-> o_pready)
      else $error("pslverr outside access");
   chk_err_single: assert property (o_pslverr |=> !o_pslverr)
      else $error("pslverr longer than one cycle");
   chk_rdata_byte: assert property (
      o_pready |-> o_prdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   chk_open_drain: assert property (
      o_clock_line_out == '0 && o_data_line_out == '0)
      else $error("line driven high");
   // Must hold through reset itself, so no disable here
   chk_por_clock_low: assert property (
      @(posedge i_clock) disable iff (1'b0)
      seen_q && !i_resetn && $past(!i_resetn) |-> o_clock_line_oe == '1)
      else $error("clock lines free in reset");
   chk_tx_data_fall: assert property (
      $changed(o_data_line_oe[0]) |->
      !i_clock_line_in[0] || $changed(o_clock_line_oe[0]))
      else $error("data moved while clock high");
   chk_tx_start_release: assert property (
      s_tx_start |-> s_clock_freed)
      else $error("clock not freed after start bit");
   chk_event_pulse: assert property (o_event[0] |=> !o_event[0])
      else $error("event longer than one cycle");
endmodule

// ==== sim/twaux_periph.sv ====
`timescale 1ns/1ps
module twaux_periph (
   // Device drive enables
   input wire logic i_dev_clk_oe,
   input wire logic i_dev_dat_oe,
   // Resolved line levels
   output logic o_clk_line,
   output logic o_dat_line
);
   logic clk_oe = 1'b0;
   logic dat_oe = 1'b0;
   // Pull-ups: a released line reads high
   assign o_clk_line = !(i_dev_clk_oe | clk_oe);
   assign o_dat_line = !(i_dev_dat_oe | dat_oe);
   // Sends nb bits with half period h; bad flips the parity bit
   task automatic send(input logic [7:0] b, input logic bad, input int nb,
      input int h);
      logic [10:0] f;
      f = {1'b1, bad ? ^b : ~^b, b, 1'b0};
      wait (o_clk_line === 1'b1);
      // Let the filtered clock level settle high before the first fall
      #(h);
      for (int i = 0; i < nb; i++)
      begin
         dat_oe = !f[i];
         #(h / 2) clk_oe = 1'b1;
         #(h) clk_oe = 1'b0;
         #(h / 2);
      end
      dat_oe = 1'b0;
   endtask
   // Clocks a device frame in and acks it at the eleventh fall
   task automatic recv(output logic [9:0] f);
      wait (o_clk_line === 1'b1 && o_dat_line === 1'b0);
      for (int i = 0; i < 11; i++)
      begin
         dat_oe = (i == 10);
         // High 80 ns and low 80 ns: a 160 ns link period
         #80 clk_oe = 1'b1;
         #80;
         if (i < 10)
            f[i] = o_dat_line;
         clk_oe = 1'b0;
      end
      #40 dat_oe = 1'b0;
   endtask
endmodule
